//--- shared/lom_pkg.sv
// Shared constants and types for the LVDS output mode and scrambler block
package lom_pkg;

  localparam int LOM_BITS = 12;
  localparam int LOM_NBUS = 4;

  // Sample width select encodings
  localparam logic [1:0] LOM_W12 = 2'h0;
  localparam logic [1:0] LOM_W11 = 2'h1;
  localparam logic [1:0] LOM_W10 = 2'h2;
  localparam logic [1:0] LOM_W8 = 2'h3;

  // Sync pattern select value that puts the strobe on the sample LSB
  localparam logic [1:0] LOM_SYNC_LSB = 2'h2;

  // Active bus masks for demux-by-one and demux-by-two, and the empty mask
  localparam logic [3:0] LOM_ACT_TWO = 4'h3;
  localparam logic [3:0] LOM_ACT_FOUR = 4'hf;
  localparam logic [3:0] LOM_ACT_NONE = 4'h0;

  localparam int LOM_LSB = 0;

  typedef struct packed {
    logic [LOM_BITS-1:0] data;
    logic strobe;
  } lom_bus_t;

  // Two samples taken together: channel A and B, or two in-order samples
  typedef struct packed {
    logic [LOM_BITS-1:0] s0;
    logic [LOM_BITS-1:0] s1;
    logic strobe;
    logic stamp;
  } lom_pair_t;

  // Word handed across to the link clock, with the settings it needs
  typedef struct packed {
    lom_bus_t [LOM_NBUS-1:0] bus;
    logic [LOM_NBUS-1:0] act;
    logic align;
    logic scramble_enable;
    logic [1:0] width;
    logic lsb_used;
    logic kill;
    logic [LOM_NBUS-1:0] stb_en;
    logic [LOM_NBUS-1:0] clk_en;
  } lom_xfer_t;

  typedef enum logic [1:0] {
    LOM_COLLECT = 2'b00,
    LOM_SECOND = 2'b01,
    LOM_WAIT = 2'b10
  } lom_state_t;

endpackage

//--- hw/lom_scrambler.sv
// Memoryless XOR scrambler for one output bus
`timescale 1ns/100ps
module lom_scrambler
  import lom_pkg::*;
(
  input wire logic enable_i,
  input wire logic [1:0] width_i,
  input wire logic lsb_used_i,
  input wire logic [LOM_BITS-1:0] data_i,
  input wire logic strobe_i,
  output logic [LOM_BITS-1:0] data_o,
  output logic strobe_o
);

  logic key;
  logic [LOM_BITS-1:0] d;

  // Only the current sample is used, so no latency is added
  always_comb begin
    key = 1'b0;
    d = data_i;
    data_o = data_i;
    strobe_o = strobe_i;
    if (enable_i) begin
      case (width_i)
        LOM_W12: begin
          key = d[0] ^ d[1];
          data_o[11:2] = d[11:2] ^ {10{key}};
          data_o[1] = d[1];
          data_o[0] = key;
          strobe_o = strobe_i ^ key;
        end
        LOM_W11: begin
          key = d[2] ^ d[1];
          data_o[11:3] = d[11:3] ^ {9{key}};
          data_o[2] = d[2];
          data_o[1] = key;
          data_o[0] = lsb_used_i ? (key ^ d[0]) : 1'b0;
          strobe_o = strobe_i ^ d[1] ^ d[0];
        end
        LOM_W10: begin
          key = d[3] ^ d[2];
          data_o[11:7] = d[11:7] ^ {5{key}};
          data_o[6:4] = d[6:4] ^ {3{key}};
          data_o[3] = d[3];
          data_o[2] = key;
          data_o[1] = 1'b0;
          data_o[0] = lsb_used_i ? (key ^ d[0]) : 1'b0;
          strobe_o = strobe_i ^ key;
        end
        default: begin
          key = d[5] ^ d[4];
          data_o[11:6] = d[11:6] ^ {6{key}};
          data_o[5] = d[5];
          data_o[4] = key;
          data_o[3:1] = 3'h0;
          data_o[0] = lsb_used_i ? (key ^ d[0]) : 1'b0;
          strobe_o = strobe_i ^ key;
        end
      endcase
    end
  end

endmodule

//--- hw/lom_output_mode.sv
// LVDS output mode formatter: demux, interleave, bus timing and gating
// Notes on behaviour
// - Demux each channel by one or two; demux one allows fewer strobes.
// - Interleave enable merges both channels into one double-rate stream.
// - Strobe on LSB (sync select 0x2) turns all dedicated strobes off.
// - Single channel, no demux: two buses, two clocks, two strobes.
// - Single channel, demux two: four buses, four clocks, four strobes.
// - Dual channel, no demux: two buses; either alignment setting allowed.
// - Dual channel, demux two: four buses, staggered or aligned timing.
// - Alignment select 0 staggers buses so one switches every instant.
// - Alignment select 1 switches all buses together at a sub-rate.
// - One strobe per bus, each disabled by its own enable bit.
// - One DDR data clock per bus, each disabled by its own bit.
// - Scramble data and strobe only when scramble enable is one.
// - Scrambling is memoryless XOR of the current sample only.
// - Scramble equations follow the sample width select setting.
// - 11-bit: upper bits XOR d2^d1, strobe XOR d1^d0.
// - Scrambled LSB always used at 12-bit; at 11/10/8-bit only with LSB select 0 and timestamp on.
// - 10-bit: bits 7-11 XOR d3^d2; receiver XORs with y2.
// - 10-bit: bits 4-6 XOR d3^d2, y3 d3, y2 d2^d3, y1 zero.
// - 8-bit: bits 6-11 XOR d5^d4, y5 d5, y4 d4^d5, bits 1-3 zero.
`timescale 1ns/100ps
module lom_output_mode
  import lom_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic pair_valid_i,
  input wire lom_pair_t pair_i,
  output logic pair_ready_o,
  input wire logic output_demux_factor_i,
  input wire logic interleave_enable_i,
  input wire logic bus_alignment_select_i,
  input wire logic scramble_enable_i,
  input wire logic [1:0] sample_width_select_i,
  input wire logic [1:0] sync_pattern_select_i,
  input wire logic lsb_function_select_i,
  input wire logic timestamp_insert_enable_i,
  input wire logic [LOM_NBUS-1:0] strobe_output_enable_i,
  input wire logic [LOM_NBUS-1:0] data_clock_output_enable_i,
  output logic [LOM_NBUS-1:0][LOM_BITS-1:0] lane_data_o,
  output logic [LOM_NBUS-1:0] bus_strobe_pair_o,
  output logic [LOM_NBUS-1:0] data_clock_o
);

  // Core side state
  lom_state_t state_ff, nxt_state;
  lom_pair_t first_ff, nxt_first;
  lom_xfer_t pay_ff, nxt_pay;
  logic req_ff, nxt_req, ready_ff, nxt_ready;
  logic ack_s1_ff, ack_s2_ff, acc;

  // Link side state
  logic lrst_s1_ff, lrst_s2_ff, req_s1_ff, req_s2_ff, req_seen_ff;
  lom_xfer_t hold_ff, nxt_hold;
  logic [LOM_NBUS-1:0] pend_ff, nxt_pend;
  logic [LOM_NBUS-1:0][LOM_BITS-1:0] data_ff, nxt_data;
  logic [LOM_NBUS-1:0] strobe_ff, nxt_strobe;
  logic [LOM_NBUS-1:0] dclk_ff, nxt_dclk;
  logic [LOM_NBUS-1:0] load, scr_strobe;
  logic [LOM_NBUS-1:0][LOM_BITS-1:0] scr_data;
  logic cap;

  assign acc = pair_valid_i & ready_ff;

  // LSB carries the strobe or the timestamp before scrambling
  function automatic lom_bus_t mk_bus(input logic [LOM_BITS-1:0] s,
                                      input logic strb,
                                      input logic stamp);
    lom_bus_t b;
    b.data = s;
    b.strobe = strb;
    if (sync_pattern_select_i == LOM_SYNC_LSB) begin
      b.data[LOM_LSB] = strb;
    end else if (!lsb_function_select_i && timestamp_insert_enable_i) begin
      b.data[LOM_LSB] = stamp;
    end
    return b;
  endfunction

  function automatic lom_xfer_t build(input lom_pair_t p0,
                                      input lom_pair_t p1,
                                      input logic four);
    lom_xfer_t x;
    x = '0;
    if (!four) begin
      x.bus[0] = mk_bus(p0.s0, p0.strobe, p0.stamp);
      x.bus[1] = mk_bus(p0.s1, p0.strobe, p0.stamp);
      x.act = LOM_ACT_TWO;
    end else if (interleave_enable_i) begin
      // One double-rate stream laid over four buses in order
      x.bus[0] = mk_bus(p0.s0, p0.strobe, p0.stamp);
      x.bus[1] = mk_bus(p0.s1, p0.strobe, p0.stamp);
      x.bus[2] = mk_bus(p1.s0, p1.strobe, p1.stamp);
      x.bus[3] = mk_bus(p1.s1, p1.strobe, p1.stamp);
      x.act = LOM_ACT_FOUR;
    end else begin
      // Each channel owns two buses, even then odd sample
      x.bus[0] = mk_bus(p0.s0, p0.strobe, p0.stamp);
      x.bus[1] = mk_bus(p1.s0, p1.strobe, p1.stamp);
      x.bus[2] = mk_bus(p0.s1, p0.strobe, p0.stamp);
      x.bus[3] = mk_bus(p1.s1, p1.strobe, p1.stamp);
      x.act = LOM_ACT_FOUR;
    end
    x.align = bus_alignment_select_i;
    x.scramble_enable = scramble_enable_i;
    x.width = sample_width_select_i;
    x.lsb_used = !lsb_function_select_i && timestamp_insert_enable_i;
    x.kill = (sync_pattern_select_i == LOM_SYNC_LSB);
    x.stb_en = strobe_output_enable_i;
    x.clk_en = data_clock_output_enable_i;
    return x;
  endfunction

  // Settings travel with each word, so no multi-bit level crosses alone
  always_comb begin
    nxt_state = state_ff;
    nxt_first = first_ff;
    nxt_pay = pay_ff;
    nxt_req = req_ff;
    case (state_ff)
      LOM_COLLECT: begin
        if (acc) begin
          nxt_first = pair_i;
          if (output_demux_factor_i) begin
            nxt_state = LOM_SECOND;
          end else begin
            nxt_pay = build(pair_i, pair_i, 1'b0);
            nxt_req = ~req_ff;
            nxt_state = LOM_WAIT;
          end
        end
      end
      LOM_SECOND: begin
        if (acc) begin
          nxt_pay = build(first_ff, pair_i, 1'b1);
          nxt_req = ~req_ff;
          nxt_state = LOM_WAIT;
        end
      end
      LOM_WAIT: begin
        if (ack_s2_ff == req_ff) begin
          nxt_state = LOM_COLLECT;
        end
      end
      default: begin
        nxt_state = LOM_COLLECT;
      end
    endcase
    nxt_ready = (nxt_state != LOM_WAIT);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= LOM_COLLECT;
      first_ff <= '0;
      pay_ff <= '0;
      req_ff <= 1'b0;
      ready_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      first_ff <= nxt_first;
      pay_ff <= nxt_pay;
      req_ff <= nxt_req;
      ready_ff <= nxt_ready;
      ack_s1_ff <= req_seen_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end
  assign pair_ready_o = ready_ff;

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lrst_s1_ff <= 1'b1;
      lrst_s2_ff <= 1'b1;
    end else begin
      lrst_s1_ff <= 1'b0;
      lrst_s2_ff <= lrst_s1_ff;
    end
  end

  for (genvar k = 0; k < LOM_NBUS; k++) begin : g_scr
    lom_scrambler u_scr (
      .enable_i(hold_ff.scramble_enable),
      .width_i(hold_ff.width),
      .lsb_used_i(hold_ff.lsb_used),
      .data_i(hold_ff.bus[k].data),
      .strobe_i(hold_ff.bus[k].strobe),
      .data_o(scr_data[k]),
      .strobe_o(scr_strobe[k])
    );
  end

  assign cap = (req_s2_ff != req_seen_ff);

  always_comb begin
    nxt_hold = hold_ff;
    nxt_pend = pend_ff;
    nxt_data = data_ff;
    nxt_strobe = strobe_ff;
    nxt_dclk = dclk_ff;
    load = LOM_ACT_NONE;
    if (cap) begin
      nxt_hold = pay_ff;
      nxt_pend = pay_ff.act;
    end else if (pend_ff != LOM_ACT_NONE) begin
      if (hold_ff.align) begin
        load = pend_ff;
      end else begin
        // One bus per link edge, lowest first
        load = pend_ff & (~pend_ff + 4'h1);
      end
      nxt_pend = pend_ff & ~load;
    end
    for (int k = 0; k < LOM_NBUS; k++) begin
      if (cap && !pay_ff.act[k]) begin
        nxt_data[k] = '0;
        nxt_strobe[k] = 1'b0;
        nxt_dclk[k] = 1'b0;
      end else if (load[k]) begin
        nxt_data[k] = scr_data[k];
      end
      if (load[k]) begin
        nxt_strobe[k] = scr_strobe[k];
        nxt_dclk[k] = ~dclk_ff[k];
      end
      if (!hold_ff.stb_en[k] || hold_ff.kill) begin
        nxt_strobe[k] = 1'b0;
      end
      if (!hold_ff.clk_en[k]) begin
        nxt_dclk[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_s2_ff) begin
    if (lrst_s2_ff) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_seen_ff <= 1'b0;
      hold_ff <= '0;
      pend_ff <= '0;
      data_ff <= '0;
      strobe_ff <= '0;
      dclk_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_seen_ff <= req_s2_ff;
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      data_ff <= nxt_data;
      strobe_ff <= nxt_strobe;
      dclk_ff <= nxt_dclk;
    end
  end

  assign lane_data_o = data_ff;
  assign bus_strobe_pair_o = strobe_ff;
  assign data_clock_o = dclk_ff;

  sequence s_capture;
    req_s2_ff != req_seen_ff;
  endsequence
  sequence s_stag_start;
    s_capture ##1 (!hold_ff.align && hold_ff.act == LOM_ACT_FOUR);
  endsequence
  demux_two_wait_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_ff == LOM_COLLECT && acc && output_demux_factor_i)
      |=> (state_ff == LOM_SECOND && req_ff == $past(req_ff)))
    else $error("demux two did not wait for second pair");
  demux_one_send_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_ff == LOM_COLLECT && acc && !output_demux_factor_i)
      |=> (state_ff == LOM_WAIT && req_ff != $past(req_ff) && !ready_ff))
    else $error("demux one pair not sent at once");
  interleave_order_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_ff == LOM_SECOND && acc && interleave_enable_i)
      |=> (pay_ff.bus[1].data[11:1] == $past(first_ff.s1[11:1])
           && pay_ff.act == LOM_ACT_FOUR))
    else $error("interleaved order wrong on bus one");
  handshake_bound_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(state_ff == LOM_WAIT) |-> ##[1:12] (state_ff == LOM_COLLECT))
    else $error("crossing handshake did not finish");
  // Inactive buses are cleared at capture, clocks and strobes as well
  unused_bus_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    (hold_ff.act == LOM_ACT_TWO)
      |-> (data_ff[2] == '0 && data_ff[3] == '0 && dclk_ff[3:2] == 2'h0
           && strobe_ff[3:2] == 2'h0))
    else $error("unused bus not quiet in two-bus mode");
  stagger_walk_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    s_stag_start |-> pend_ff == LOM_ACT_FOUR ##1 pend_ff == 4'he
      ##1 pend_ff == 4'hc ##1 pend_ff == 4'h8 ##1 pend_ff == 4'h0)
    else $error("staggered buses not loaded one per edge");
  aligned_load_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    (hold_ff.align && pend_ff != LOM_ACT_NONE && !cap)
      |=> (pend_ff == LOM_ACT_NONE && dclk_ff ==
           (($past(dclk_ff) ^ $past(pend_ff)) & $past(hold_ff.clk_en))))
    else $error("aligned buses did not switch together");
  strobe_gate_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    1'b1 |=> ((strobe_ff & ~$past(hold_ff.stb_en)) == LOM_ACT_NONE))
    else $error("disabled strobe is active");
  lsb_strobe_off_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    hold_ff.kill |=> (strobe_ff == LOM_ACT_NONE))
    else $error("strobe on LSB left dedicated strobe on");
  clock_gate_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    1'b1 |=> ((dclk_ff & ~$past(hold_ff.clk_en)) == LOM_ACT_NONE))
    else $error("disabled data clock toggles");
  scramble_off_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    (load[0] && !hold_ff.scramble_enable)
      |=> (data_ff[0] == $past(hold_ff.bus[0].data)))
    else $error("data altered with scrambling off");
  scramble_twelve_a: assert property (
    @(posedge link_clk_i) disable iff (lrst_s2_ff)
    (load[0] && hold_ff.scramble_enable && hold_ff.width == LOM_W12)
      |=> (data_ff[0][1] == $past(hold_ff.bus[0].data[1])
           && data_ff[0][0] == ($past(hold_ff.bus[0].data[0])
                                ^ $past(hold_ff.bus[0].data[1]))
           && data_ff[0][11:2] == ($past(hold_ff.bus[0].data[11:2])
              ^ {10{data_ff[0][0]}})))
    else $error("12-bit scramble equation broken");

endmodule

//--- verification/lom_rx_model.sv
// Receiver model: descrambles the four output buses like a capturing FPGA
`timescale 1ns/100ps
module lom_rx_model
  import lom_pkg::*;
(
  input wire logic scr_i,
  input wire logic [1:0] width_i,
  input wire logic [LOM_NBUS-1:0][LOM_BITS-1:0] lane_i,
  input wire logic [LOM_NBUS-1:0] strobe_i,
  output logic [LOM_NBUS-1:0][LOM_BITS-1:0] data_o,
  output logic [LOM_NBUS-1:0] strobe_o
);
  // Current word only, so recovery adds no latency
  always_comb begin
    for (int b = 0; b < LOM_NBUS; b++) begin
      data_o[b] = lane_i[b];
      strobe_o[b] = strobe_i[b];
      if (scr_i) begin
        case (width_i)
          LOM_W12: begin
            data_o[b] = lane_i[b] ^ {{10{lane_i[b][0]}}, 2'h0};
            data_o[b][0] = lane_i[b][0] ^ lane_i[b][1];
            strobe_o[b] = strobe_i[b] ^ lane_i[b][0];
          end
          LOM_W11: begin
            data_o[b] = lane_i[b] ^ {{9{lane_i[b][1]}}, 3'h0};
            data_o[b][1] = lane_i[b][2] ^ lane_i[b][1];
            data_o[b][0] = lane_i[b][1] ^ lane_i[b][0];
            strobe_o[b] = strobe_i[b] ^ lane_i[b][1];
          end
          LOM_W10: begin
            data_o[b] = lane_i[b] ^ {{8{lane_i[b][2]}}, 4'h0};
            data_o[b][2] = lane_i[b][2] ^ lane_i[b][3];
            data_o[b][1] = 1'b0;
            data_o[b][0] = lane_i[b][0] ^ lane_i[b][2];
            strobe_o[b] = strobe_i[b] ^ lane_i[b][2];
          end
          default: begin
            data_o[b] = lane_i[b] ^ {{6{lane_i[b][4]}}, 6'h0};
            data_o[b][4] = lane_i[b][4] ^ lane_i[b][5];
            data_o[b][3:1] = 3'h0;
            data_o[b][0] = lane_i[b][0] ^ lane_i[b][4];
            strobe_o[b] = strobe_i[b] ^ lane_i[b][4];
          end
        endcase
      end
    end
  end
endmodule

//--- verification/test_lom_output_mode.sv
// Self-checking bench for the LVDS output mode formatter
`timescale 1ns/100ps
module test_lom_output_mode
  import lom_pkg::*;
;
  logic clk_i, reset_i, link_clk_i, pair_valid_i, pair_ready_o;
  lom_pair_t pair_i;
  logic demux, ilv, align, scramble_enable, lsbsel, tsen;
  logic [1:0] width, sync;
  logic [3:0] stben, clken, stb, dclk, dclk_was, first;
  logic [3:0][11:0] lane, rx_data;
  logic [3:0] rx_stb;
  logic [11:0] msk [0:3];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  lom_output_mode dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .link_clk_i(link_clk_i), .pair_valid_i(pair_valid_i), .pair_i(pair_i),
    .pair_ready_o(pair_ready_o), .output_demux_factor_i(demux),
    .interleave_enable_i(ilv), .bus_alignment_select_i(align),
    .scramble_enable_i(scramble_enable), .sample_width_select_i(width),
    .sync_pattern_select_i(sync), .lsb_function_select_i(lsbsel),
    .timestamp_insert_enable_i(tsen), .strobe_output_enable_i(stben),
    .data_clock_output_enable_i(clken), .lane_data_o(lane),
    .bus_strobe_pair_o(stb), .data_clock_o(dclk));

  lom_rx_model rx_u (.scr_i(scramble_enable), .width_i(width), .lane_i(lane),
    .strobe_i(stb), .data_o(rx_data), .strobe_o(rx_stb));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Link clock runs free, phase unrelated to the core clock
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs about a hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_rdy(input logic v);
    for (int n = 0; n < 40 && pair_ready_o !== v; n++) @(negedge clk_i);
    if (pair_ready_o !== v) chk("pair_ready_o", {47'h0, v}, {47'h0, pair_ready_o});
  endtask

  task automatic put(input lom_pair_t p);
    pair_i = p;
    pair_valid_i = 1'b1;
    wait_rdy(1'b1);
    @(negedge clk_i);
  endtask

  task automatic cfg(input logic dm, il, al, sc, input logic [1:0] w, sy,
                     input logic [3:0] se, ce);
    demux = dm;
    ilv = il;
    align = al;
    scramble_enable = sc;
    width = w;
    sync = sy;
    stben = se;
    clken = ce;
  endtask

  // One word; first holds the enabled clocks that moved on the first load of an enabled bus
  task automatic word(input lom_pair_t p0, input lom_pair_t p1);
    dclk_was = dclk;
    put(p0);
    if (demux) put(p1);
    pair_valid_i = 1'b0;
    wait_rdy(1'b0);
    // A disabled clock may fall when the enables change; only enabled count
    for (int n = 0; n < 400 && ((dclk ^ dclk_was) & clken) === 4'h0;
         n++) #1;
    #1;
    first = (dclk ^ dclk_was) & clken;
    @(negedge clk_i);
    wait_rdy(1'b1);
    // Staggered loads finish within four link edges of capture
    repeat (5) @(negedge clk_i);
  endtask

  initial begin
    lom_pair_t a, b;
    reset_i = 1'b1;
    pair_valid_i = 1'b0;
    pair_i = '0;
    lsbsel = 1'b0;
    tsen = 1'b0;
    msk = '{12'hfff, 12'hfff, 12'hffd, 12'hff1};
    cfg(1'b0, 1'b0, 1'b1, 1'b0, LOM_W12, 2'h0, 4'hf, 4'hf);
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    a = {12'h5a3, 12'hc36, 1'b1, 1'b0};
    word(a, a);
    chk("lane_data_o", {24'h0, 12'hc36, 12'h5a3}, lane);
    chk("bus_strobe_pair_o", {44'h0, 4'h3}, {44'h0, stb});
    chk("data_clock_o", {44'h0, 4'h3}, {44'h0, dclk ^ dclk_was});
    cfg(1'b1, 1'b1, 1'b1, 1'b0, LOM_W12, 2'h0, 4'hf, 4'hf);
    a = {12'h111, 12'h222, 1'b0, 1'b0};
    b = {12'h333, 12'h444, 1'b0, 1'b0};
    word(a, b);
    chk("lane_data_o", {12'h444, 12'h333, 12'h222, 12'h111}, lane);
    chk("first_clocks", {44'h0, 4'hf}, {44'h0, first});
    chk("bus_strobe_pair_o", 48'h0, {44'h0, stb});
    cfg(1'b1, 1'b0, 1'b0, 1'b0, LOM_W12, 2'h0, 4'h5, 4'h6);
    a = {12'h0a1, 12'h0b1, 1'b1, 1'b0};
    b = {12'h0a2, 12'h0b2, 1'b1, 1'b0};
    word(a, b);
    chk("lane_data_o", {12'h0b2, 12'h0b1, 12'h0a2, 12'h0a1}, lane);
    chk("first_clocks", {44'h0, 4'h2}, {44'h0, first});
    chk("bus_strobe_pair_o", {44'h0, 4'h5}, {44'h0, stb});
    chk("data_clock_o", {40'h0, 4'h0, 4'h6},
        {40'h0, dclk & ~clken, (dclk ^ dclk_was) & clken});
    cfg(1'b1, 1'b1, 1'b1, 1'b0, LOM_W12, LOM_SYNC_LSB, 4'hf, 4'hf);
    a = {12'h100, 12'h200, 1'b1, 1'b0};
    b = {12'h300, 12'h400, 1'b1, 1'b0};
    word(a, b);
    chk("lane_data_o", {12'h401, 12'h301, 12'h201, 12'h101}, lane);
    chk("bus_strobe_pair_o", 48'h0, {44'h0, stb});
    // Stamp on the LSB so the scrambled y0 is in use at every width
    tsen = 1'b1;
    for (int w = 0; w < 4; w++) begin
      cfg(1'b0, 1'b0, 1'b1, 1'b1, w[1:0], 2'h0, 4'hf, 4'hf);
      a = {12'h9c6, 12'h35a, 1'b1, 1'b1};
      word(a, a);
      chk("rx_data", {24'h0, 12'h35b & msk[w], 12'h9c7 & msk[w]},
          {24'h0, rx_data[1] & msk[w], rx_data[0] & msk[w]});
      if (w != 1) chk("rx_strobe", {46'h0, 2'h3}, {46'h0, rx_stb[1:0]});
    end
    // Stamp not selected: scrambled LSB stays unused although d0 is set
    lsbsel = 1'b1;
    cfg(1'b0, 1'b0, 1'b1, 1'b1, LOM_W10, 2'h0, 4'hf, 4'hf);
    a = {12'h9c3, 12'h35a, 1'b1, 1'b1};
    word(a, a);
    chk("lane_data_o", 48'h0, {47'h0, lane[0][0]});
    give_verdict();
  end
endmodule
